/* File: src/icmd_top.sv */
// Instruction classification, exception request and computation-mode stage.
`include "icmd_regs.svh"
module icmd_top #(
  parameter bit IMPL64 = 1'b1,
  parameter bit HAS_BRIDGE = 1'b0,
  parameter bit OPT_FSQRT = 1'b1,
  parameter bit OPT_GRAPH = 1'b1,
  parameter bit OPT_EXTCTL = 1'b0,
  parameter bit OPT_TLB = 1'b1
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Fetch side.
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_instr,
  output logic fetch_ready,
  // Machine state and operands.
  input wire logic [63:0] msr_val,
  input wire logic [63:0] base_val,
  input wire logic [63:0] index_val,
  input wire logic [63:0] result_val,
  input wire logic [63:0] loop_count_register,
  // Exception unit.
  input wire logic async_req,
  input wire logic exc_done,
  output logic async_take,
  output logic illegal_req,
  output logic dec_valid,
  output icmd_pkg::icmd_class_e dec_class,
  // Execution side.
  output logic issue_valid,
  output logic [31:0] issue_instr,
  output logic mode64,
  output logic cmp_word,
  output logic loop_count_zero,
  output logic slow_form,
  output logic nop_hint,
  output logic [63:0] mem_addr,
  output logic [63:0] update_ea,
  output logic [63:0] link_return_ea,
  output logic [63:0] wr_data
);
  // =====================================================================
  // Declarations
  icmd_core_if core ();
  icmd_pkg::icmd_state_e state_r;
  icmd_pkg::icmd_state_e state_nxt;
  icmd_pkg::icmd_class_e cls;
  icmd_pkg::icmd_class_e dec_class_r;
  logic fetch_ready_r;
  logic async_take_r;
  logic illegal_req_r;
  logic dec_valid_r;
  logic issue_valid_r;
  logic [31:0] issue_instr_r;
  logic mode64_r;
  logic mode64_nxt;
  logic cmp_word_r;
  logic loop_count_zero_r;
  logic slow_form_r;
  logic nop_hint_r;
  logic [63:0] mem_addr_r;
  logic [63:0] update_ea_r;
  logic [63:0] link_return_ea_r;
  logic [63:0] wr_data_r;
  logic [5:0] op;
  logic [9:0] xo;
  logic [4:0] axo;
  logic need64;
  logic need32br;
  logic needbr;
  logic opt_miss;
  logic width_bad;
  logic ill_any;
  logic accept;
  logic slow;
  // =====================================================================
  // Submodules
  icmd_form_check #(.IMPL64(IMPL64)) u_chk (.bus(core.chk));
  icmd_ea_unit #(.IMPL64(IMPL64)) u_ea (.bus(core.ea));
  assign core.instr = fetch_instr;
  assign core.op_a = base_val;
  assign core.op_b = index_val;
  assign core.mode64 = mode64_nxt;
  assign op = fetch_instr[`ICMD_F_OPCD];
  assign xo = fetch_instr[`ICMD_F_XO];
  assign axo = fetch_instr[`ICMD_F_AXO];
  assign mode64_nxt = IMPL64 && msr_val[`ICMD_MSR_MODE];
  assign accept = fetch_valid && fetch_ready_r;
  // =====================================================================
  // Opcode classification
  // primary and extended opcode
  always_comb begin
    cls = icmd_pkg::CLS_DEF;
    need64 = 1'b0;
    need32br = 1'b0;
    needbr = 1'b0;
    opt_miss = 1'b0;
    case (op)
      `ICMD_OP_ZERO: begin
        if (fetch_instr != '0 && xo == `ICMD_ATTN_XO) begin
          cls = icmd_pkg::CLS_RSV;
        end else begin
          cls = icmd_pkg::CLS_ILL;
        end
      end
      6'h01, 6'h04, 6'h05, 6'h06, 6'h09, 6'h16, 6'h38, 6'h39, 6'h3c, 6'h3d: begin
        cls = icmd_pkg::CLS_ILL;
      end
      `ICMD_OP_TDI: need64 = 1'b1;
      `ICMD_OP_X19: begin
        case (xo)
          10'h000, 10'h010, 10'h021, 10'h081, 10'h0c1, 10'h0e1, 10'h101,
          10'h121, 10'h1a1, 10'h1c1, 10'h210, 10'h096: cls = icmd_pkg::CLS_DEF;
          10'h012: need64 = 1'b1;
          10'h032: need32br = 1'b1;
          default: cls = icmd_pkg::CLS_ILL;
        endcase
      end
      `ICMD_OP_RLD: begin
        need64 = 1'b1;
        if (fetch_instr[`ICMD_F_MDXO] > 3'h4 &&
            fetch_instr[`ICMD_F_MDSXO] != 4'h8 && fetch_instr[`ICMD_F_MDSXO] != 4'h9) begin
          cls = icmd_pkg::CLS_ILL;
        end
      end
      `ICMD_OP_X31: begin
        case (xo)
          10'h015, 10'h035, 10'h095, 10'h0b5, 10'h01b, 10'h21b, 10'h31a, 10'h03a,
          10'h009, 10'h049, 10'h0e9, 10'h1e9, 10'h1c9, 10'h2e9, 10'h3e9, 10'h3c9,
          10'h054, 10'h0d6, 10'h155, 10'h175, 10'h3da, 10'h044, 10'h33a, 10'h33b: begin
            need64 = 1'b1;
          end
          10'h0d2, 10'h0f2, 10'h253, 10'h293: need32br = 1'b1;
          10'h052, 10'h072: needbr = 1'b1;
          10'h136, 10'h1b6: opt_miss = !OPT_EXTCTL;
          10'h172, 10'h132, 10'h112, 10'h236: opt_miss = !OPT_TLB;
          10'h1f2, 10'h1b2: begin
            need64 = 1'b1;
            opt_miss = !OPT_TLB;
          end
          default: cls = icmd_pkg::CLS_DEF;
        endcase
      end
      `ICMD_OP_LD64: begin
        need64 = 1'b1;
        if (fetch_instr[`ICMD_F_DS] == 2'h3) begin
          cls = icmd_pkg::CLS_ILL;
        end
      end
      `ICMD_OP_ST64: begin
        need64 = 1'b1;
        if (fetch_instr[`ICMD_F_DS] > 2'h1) begin
          cls = icmd_pkg::CLS_ILL;
        end
      end
      `ICMD_OP_FP59: begin
        case (axo)
          5'h12, 5'h14, 5'h15, 5'h19, 5'h1c, 5'h1d, 5'h1e, 5'h1f: cls = icmd_pkg::CLS_DEF;
          5'h16: opt_miss = !OPT_FSQRT;
          5'h18: opt_miss = !OPT_GRAPH;
          default: cls = icmd_pkg::CLS_ILL;
        endcase
      end
      `ICMD_OP_FP63: begin
        if (axo[4]) begin
          case (axo)
            5'h12, 5'h14, 5'h15, 5'h19, 5'h1c, 5'h1d, 5'h1e, 5'h1f: cls = icmd_pkg::CLS_DEF;
            5'h16: opt_miss = !OPT_FSQRT;
            5'h17, 5'h1a: opt_miss = !OPT_GRAPH;
            default: cls = icmd_pkg::CLS_ILL;
          endcase
        end else begin
          case (xo)
            10'h000, 10'h00c, 10'h00e, 10'h00f, 10'h020, 10'h026, 10'h028, 10'h040,
            10'h046, 10'h048, 10'h086, 10'h088, 10'h108, 10'h247, 10'h2c7: begin
              cls = icmd_pkg::CLS_DEF;
            end
            10'h32e, 10'h32f, 10'h34e: need64 = 1'b1;
            default: cls = icmd_pkg::CLS_ILL;
          endcase
        end
      end
      default: cls = icmd_pkg::CLS_DEF;
    endcase
  end
  // =====================================================================
  // Trap request
  // width-specific instructions
  assign width_bad = (need64 && !IMPL64) || (need32br && IMPL64 && !HAS_BRIDGE) ||
                     (needbr && !(IMPL64 && HAS_BRIDGE));
  assign ill_any = (cls != icmd_pkg::CLS_DEF) || width_bad || opt_miss || core.bad;
  assign slow = (op == `ICMD_OP_X31) && (xo == 10'h090) &&
                !$onehot(fetch_instr[`ICMD_F_FXM]);
  // =====================================================================
  // Sequencer
  // stop fetch after trap
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      icmd_pkg::ST_RUN: begin
        if ((accept && ill_any) || async_req) begin
          state_nxt = icmd_pkg::ST_TRAP;
        end
      end
      icmd_pkg::ST_TRAP: begin
        if (exc_done) begin
          state_nxt = icmd_pkg::ST_RUN;
        end
      end
      default: state_nxt = icmd_pkg::ST_RUN;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= icmd_pkg::ST_RUN;
      fetch_ready_r <= 1'b1;
      async_take_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      fetch_ready_r <= (state_nxt == icmd_pkg::ST_RUN);
      async_take_r <= (state_r == icmd_pkg::ST_RUN) && async_req && !(accept && ill_any);
    end
  end
  // =====================================================================
  // Decode outputs
  // class with request
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dec_valid_r <= 1'b0;
      illegal_req_r <= 1'b0;
      issue_valid_r <= 1'b0;
      dec_class_r <= icmd_pkg::CLS_DEF;
      issue_instr_r <= '0;
      slow_form_r <= 1'b0;
      nop_hint_r <= 1'b0;
    end else begin
      dec_valid_r <= accept;
      illegal_req_r <= accept && ill_any;
      issue_valid_r <= accept && !ill_any;
      if (accept) begin
        dec_class_r <= width_bad ? icmd_pkg::CLS_ILL : cls;
        issue_instr_r <= fetch_instr;
        slow_form_r <= slow;
        nop_hint_r <= (fetch_instr == `ICMD_NOP_WORD);
      end
    end
  end
  // =====================================================================
  // Mode-dependent datapath
  // mode steers compare and test
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode64_r <= IMPL64;
      cmp_word_r <= !IMPL64;
      loop_count_zero_r <= 1'b0;
      mem_addr_r <= '0;
      update_ea_r <= '0;
      link_return_ea_r <= '0;
      wr_data_r <= '0;
    end else begin
      mode64_r <= mode64_nxt;
      cmp_word_r <= !mode64_nxt;
      loop_count_zero_r <= mode64_nxt ? (loop_count_register == '0) :
                           (loop_count_register[`ICMD_F_LO32] == '0);
      mem_addr_r <= core.mem_addr;
      update_ea_r <= core.ea_sum;
      link_return_ea_r <= core.mem_addr;
      wr_data_r <= IMPL64 ? result_val : {`ICMD_HI_ZERO, result_val[`ICMD_F_LO32]};
    end
  end
  assign fetch_ready = fetch_ready_r;
  assign async_take = async_take_r;
  assign illegal_req = illegal_req_r;
  assign dec_valid = dec_valid_r;
  assign dec_class = dec_class_r;
  assign issue_valid = issue_valid_r;
  assign issue_instr = issue_instr_r;
  assign mode64 = mode64_r;
  assign cmp_word = cmp_word_r;
  assign loop_count_zero = loop_count_zero_r;
  assign slow_form = slow_form_r;
  assign nop_hint = nop_hint_r;
  assign mem_addr = mem_addr_r;
  assign update_ea = update_ea_r;
  assign link_return_ea = link_return_ea_r;
  assign wr_data = wr_data_r;
  // =====================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  zero_word_ill_a: assert property (accept && fetch_instr == '0 |=>
    illegal_req_r && dec_class_r == icmd_pkg::CLS_ILL) else $error("zero word not illegal");
  trap_no_issue_a: assert property (illegal_req_r |-> !issue_valid_r && !fetch_ready_r)
    else $error("trapped word issued");
  trap_holds_a: assert property (illegal_req_r && !exc_done |=> !dec_valid_r)
    else $error("decode continued after trap");
  mode_pick_a: assert property (##1 mode64_r ==
    (IMPL64 && $past(msr_val[`ICMD_MSR_MODE]))) else $error("mode not taken from mode bit");
  addr_low_a: assert property (!mode64_r |-> mem_addr_r[`ICMD_F_HI32] == '0)
    else $error("high address bits in narrow mode");
  write_full_a: assert property (IMPL64 |=> wr_data_r == $past(result_val))
    else $error("write data altered");
  opt_trap_a: assert property (accept && opt_miss |=> illegal_req_r)
    else $error("missing optional did not trap");
  event_take_a: assert property (fetch_ready_r && async_req && !accept |=>
    async_take_r && !fetch_ready_r) else $error("event not taken");
  loop_test_a: assert property (!mode64_r && loop_count_zero_r |->
    $past(loop_count_register[`ICMD_F_LO32]) == '0) else $error("loop test width wrong");
  legal_pass_a: assert property (accept && !ill_any |=> issue_valid_r && !illegal_req_r)
    else $error("legal word rejected");
endmodule : icmd_top

/* File: include/icmd_regs.svh */
// Field positions, opcodes and constant words for the instruction decode stage.
`ifndef ICMD_REGS_SVH
`define ICMD_REGS_SVH
`define ICMD_F_OPCD 31:26
`define ICMD_F_RT 25:21
`define ICMD_F_RA 20:16
`define ICMD_F_RB 15:11
`define ICMD_F_XO 10:1
`define ICMD_F_AXO 5:1
`define ICMD_F_DS 1:0
`define ICMD_F_MDXO 4:2
`define ICMD_F_MDSXO 4:1
`define ICMD_F_FXM 19:12
`define ICMD_F_LO32 31:0
`define ICMD_F_HI32 63:32
`define ICMD_B_CMPL 21
`define ICMD_B_CMPRSV 22
`define ICMD_B_BODEC 23
`define ICMD_B_XRSV 0
`define ICMD_MSR_MODE 63
`define ICMD_NOP_WORD 32'h6000_0000
`define ICMD_ATTN_XO 10'h100
`define ICMD_OP_ZERO 6'h00
`define ICMD_OP_TDI 6'h02
`define ICMD_OP_CMPLI 6'h0a
`define ICMD_OP_CMPI 6'h0b
`define ICMD_OP_X19 6'h13
`define ICMD_OP_RLD 6'h1e
`define ICMD_OP_X31 6'h1f
`define ICMD_OP_LMW 6'h2e
`define ICMD_OP_LD64 6'h3a
`define ICMD_OP_FP59 6'h3b
`define ICMD_OP_ST64 6'h3e
`define ICMD_OP_FP63 6'h3f
`define ICMD_HI_ZERO 32'h0000_0000
`endif

/* File: include/icmd_pkg.sv */
// Types shared by the instruction decode stage.
package icmd_pkg;
  typedef enum logic [1:0] {
    CLS_DEF = 2'b00,
    CLS_ILL = 2'b01,
    CLS_RSV = 2'b10
  } icmd_class_e;
  typedef enum logic {
    ST_RUN = 1'b0,
    ST_TRAP = 1'b1
  } icmd_state_e;
endpackage : icmd_pkg

/* File: include/icmd_core_if.sv */
// Carrier between the decode stage and its form checker and address unit.
interface icmd_core_if;
  logic [31:0] instr;
  logic bad;
  logic mode64;
  logic [63:0] op_a;
  logic [63:0] op_b;
  logic [63:0] ea_sum;
  logic [63:0] mem_addr;
  modport top (output instr, output mode64, output op_a, output op_b,
               input bad, input ea_sum, input mem_addr);
  modport chk (input instr, output bad);
  modport ea (input mode64, input op_a, input op_b,
              output ea_sum, output mem_addr);
endinterface : icmd_core_if

/* File: src/icmd_form_check.sv */
// Detection of invalid operand encodings in defined instructions.
`include "icmd_regs.svh"
module icmd_form_check #(
  parameter bit IMPL64 = 1'b1
) (
  // Instruction in, verdict out.
  icmd_core_if.chk bus
);
  logic [5:0] op;
  logic [4:0] rt;
  logic [4:0] ra;
  logic [4:0] rb;
  logic [9:0] xo;
  logic ra_bad;
  logic cmp_bad;
  assign op = bus.instr[`ICMD_F_OPCD];
  assign rt = bus.instr[`ICMD_F_RT];
  assign ra = bus.instr[`ICMD_F_RA];
  assign rb = bus.instr[`ICMD_F_RB];
  assign xo = bus.instr[`ICMD_F_XO];
  assign ra_bad = (ra == 5'h00) || (ra == rt);
  assign cmp_bad = bus.instr[`ICMD_B_CMPRSV] || (!IMPL64 && bus.instr[`ICMD_B_CMPL]);
  // =====================================================================
  // Operand checks
  // reserved bits and operands
  always_comb begin
    bus.bad = 1'b0;
    case (op)
      6'h21, 6'h23, 6'h29, 6'h2b: bus.bad = ra_bad;
      6'h25, 6'h27, 6'h2d, 6'h31, 6'h33, 6'h35, 6'h37: bus.bad = (ra == 5'h00);
      `ICMD_OP_LMW: bus.bad = (ra >= rt);
      `ICMD_OP_LD64: bus.bad = (bus.instr[`ICMD_F_DS] == 2'h1) && ra_bad;
      `ICMD_OP_ST64: bus.bad = (bus.instr[`ICMD_F_DS] == 2'h1) && (ra == 5'h00);
      `ICMD_OP_CMPLI, `ICMD_OP_CMPI: bus.bad = cmp_bad;
      `ICMD_OP_X19: begin
        if (xo == 10'h010 || xo == 10'h210) begin
          bus.bad = (rb != 5'h00) || (xo == 10'h210 && !bus.instr[`ICMD_B_BODEC]);
        end
      end
      `ICMD_OP_X31: begin
        case (xo)
          10'h000, 10'h020: bus.bad = cmp_bad || bus.instr[`ICMD_B_XRSV];
          10'h037, 10'h077, 10'h137, 10'h177, 10'h035, 10'h175: bus.bad = ra_bad;
          10'h0b7, 10'h0f7, 10'h1b7, 10'h0b5, 10'h237, 10'h277, 10'h2b7, 10'h2f7: begin
            bus.bad = (ra == 5'h00);
          end
          10'h255: bus.bad = (ra == rt);
          10'h215: bus.bad = (ra == rt) || (rb == rt);
          default: bus.bad = 1'b0;
        endcase
      end
      default: bus.bad = 1'b0;
    endcase
  end
endmodule : icmd_form_check

/* File: src/icmd_ea_unit.sv */
// Effective address sum and mode-dependent memory address.
`include "icmd_regs.svh"
module icmd_ea_unit #(
  parameter bit IMPL64 = 1'b1
) (
  // Operands in, addresses out.
  icmd_core_if.ea bus
);
  logic [63:0] a;
  logic [63:0] b;
  logic [63:0] sum;
  // =====================================================================
  // Address arithmetic
  always_comb begin
    a = IMPL64 ? bus.op_a : {`ICMD_HI_ZERO, bus.op_a[`ICMD_F_LO32]};
    b = IMPL64 ? bus.op_b : {`ICMD_HI_ZERO, bus.op_b[`ICMD_F_LO32]};
    sum = a + b;
    bus.ea_sum = sum;
    bus.mem_addr = bus.mode64 ? sum : {`ICMD_HI_ZERO, sum[`ICMD_F_LO32]};
  end
endmodule : icmd_ea_unit

/* File: tb/icmd_fetch_model.sv */
// Fetch-side and exception-side partner model of the decode stage.
module icmd_fetch_model (
  // Clock.
  input wire logic sys_clk,
  // Decode stage answers.
  input wire logic fetch_ready,
  input wire logic illegal_req,
  input wire logic async_take,
  // Requests towards the decode stage.
  output logic fetch_valid,
  output logic [31:0] fetch_instr,
  output logic async_req,
  output logic exc_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int exc_wait = 1;

  initial begin
    fetch_valid = 1'b0;
    fetch_instr = 32'h0000_0000;
    async_req = 1'b0;
    exc_done = 1'b0;
  end

  // ==========================================================
  // Fetch side
  // Offers a word once ready, holds it to the taking edge, then releases it only for the last word.
  task automatic send(input logic [31:0] word, input bit last);
    int n;
    n = 0;
    while (fetch_ready !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    fetch_valid = 1'b1;
    fetch_instr = word;
    @(posedge sys_clk);
    #1;
    if (last) begin
      fetch_valid = 1'b0;
      fetch_instr = ~word;
    end
  endtask : send

  // Raises an asynchronous event, held until it is taken.
  task automatic raise_event();
    async_req = 1'b1;
  endtask : raise_event

  // ==========================================================
  // Exception side
  // Restarts the stage a settable number of cycles after a trap or event.
  always @(posedge sys_clk) begin
    #1;
    if (illegal_req === 1'b1 || async_take === 1'b1) begin
      if (async_take === 1'b1) begin
        async_req = 1'b0;
      end
      repeat (exc_wait) @(posedge sys_clk);
      #1;
      exc_done = 1'b1;
      @(posedge sys_clk);
      #1;
      exc_done = 1'b0;
    end
  end
endmodule : icmd_fetch_model

/* File: tb/instr_class_mode_decoder_tb_top.sv */
// Self-checking bench for the instruction decode stage.
`define CHK(act, exp, msg) \
  begin \
    checks_done++; \
    if ((act) !== (exp)) begin \
      failures++; \
      $display("MISMATCH t=%0t %s", $time, msg); \
    end \
  end
module instr_class_mode_decoder_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic fetch_valid, fetch_ready, async_req, exc_done, async_take, illegal_req;
  logic dec_valid, issue_valid, mode64, cmp_word, loop_count_zero, slow_form, nop_hint;
  logic [31:0] fetch_instr, issue_instr;
  logic [63:0] msr_val = 64'h8000_0000_0000_0000;
  logic [63:0] base_val = 64'h0000_0000_0000_0000;
  logic [63:0] index_val = 64'h0000_0000_0000_0000;
  logic [63:0] result_val = 64'h0000_0000_0000_0000;
  logic [63:0] loop_count_register = 64'h0000_0000_0000_0000;
  logic [63:0] mem_addr, update_ea, link_return_ea, wr_data;
  icmd_pkg::icmd_class_e dec_class;
  int failures = 0;
  int checks_done = 0;
  // Zero, primary 1, attention, missing optional, return, bad update, add, root, trap.
  logic [31:0] words [9] = '{32'h0000_0000, 32'h0400_0000, 32'h0000_0200,
    32'h7c00_026c, 32'h4c00_0064, 32'h8420_0000, 32'h7c22_1a14, 32'hfc20_102c,
    32'h08a3_0004};
  icmd_pkg::icmd_class_e cls [9] = '{icmd_pkg::CLS_ILL, icmd_pkg::CLS_ILL,
    icmd_pkg::CLS_RSV, icmd_pkg::CLS_DEF, icmd_pkg::CLS_ILL, icmd_pkg::CLS_DEF,
    icmd_pkg::CLS_DEF, icmd_pkg::CLS_DEF, icmd_pkg::CLS_DEF};
  logic traps [9] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  // No-op, field move with two fields, field move with one field.
  logic [31:0] burst [3] = '{32'h6000_0000, 32'h7c20_3120, 32'h7c20_1120};

  always #4 sys_clk = ~sys_clk;

  icmd_top u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .fetch_valid(fetch_valid),
    .fetch_instr(fetch_instr), .fetch_ready(fetch_ready), .msr_val(msr_val),
    .base_val(base_val), .index_val(index_val), .result_val(result_val),
    .loop_count_register(loop_count_register), .async_req(async_req),
    .exc_done(exc_done), .async_take(async_take), .illegal_req(illegal_req),
    .dec_valid(dec_valid), .dec_class(dec_class), .issue_valid(issue_valid),
    .issue_instr(issue_instr), .mode64(mode64), .cmp_word(cmp_word),
    .loop_count_zero(loop_count_zero), .slow_form(slow_form), .nop_hint(nop_hint),
    .mem_addr(mem_addr), .update_ea(update_ea), .link_return_ea(link_return_ea),
    .wr_data(wr_data));

  icmd_fetch_model u_fm (.sys_clk(sys_clk), .fetch_ready(fetch_ready),
    .illegal_req(illegal_req), .async_take(async_take), .fetch_valid(fetch_valid),
    .fetch_instr(fetch_instr), .async_req(async_req), .exc_done(exc_done));

  // ==========================================================
  // Closing and helpers
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic wait_ready();
    int n;
    n = 0;
    while (fetch_ready !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    `CHK(fetch_ready, 1'b1, "stage did not restart")
  endtask : wait_ready

  // ==========================================================
  // Scenarios
  task automatic test_reset();
    `CHK(mode64, 1'b1, "reset mode")
    `CHK(cmp_word, 1'b0, "reset compare width")
    `CHK(fetch_ready, 1'b1, "reset ready")
    `CHK(dec_class, icmd_pkg::CLS_DEF, "reset class")
    $display("test reset done");
  endtask : test_reset

  task automatic test_classes();
    for (int i = 0; i < 9; i++) begin
      u_fm.exc_wait = (i % 2 == 1) ? 5 : 1;
      u_fm.send(words[i], i == 8);
      `CHK(dec_valid, 1'b1, "decode pulse")
      `CHK(dec_class, cls[i], "class")
      `CHK(illegal_req, traps[i], "trap request")
      `CHK(issue_valid, ~traps[i], "issue")
      `CHK(fetch_ready, ~traps[i], "stall after trap")
    end
    wait_ready();
    $display("test classes done");
  endtask : test_classes

  task automatic test_burst();
    @(posedge sys_clk);
    #1;
    for (int i = 0; i < 3; i++) begin
      u_fm.send(burst[i], i == 2);
      `CHK(issue_valid, 1'b1, "burst issue")
      `CHK(issue_instr, burst[i], "burst order")
      `CHK(nop_hint, i == 0, "no-op hint")
      `CHK(slow_form, i == 1, "slow form")
    end
    $display("test burst done");
  endtask : test_burst

  task automatic test_mode();
    logic mb;
    logic [63:0] sum;
    @(posedge sys_clk);
    #1;
    for (int k = 0; k < 2; k++) begin
      mb = k[0];
      msr_val = {mb, 63'h0};
      base_val = 64'hffff_ffff_8000_0000;
      index_val = 64'h0000_0001_8000_0010;
      result_val = 64'h1234_5678_9abc_def0;
      loop_count_register = 64'h0000_0005_0000_0000;
      sum = base_val + index_val;
      u_fm.send(32'h08a3_0004, k == 1);
      `CHK(issue_valid, 1'b1, "wide-only word in narrow mode")
      `CHK(mode64, mb, "mode")
      `CHK(cmp_word, ~mb, "compare width")
      `CHK(loop_count_zero, ~mb, "loop test width")
      `CHK(mem_addr, mb ? sum : {32'h0000_0000, sum[31:0]}, "memory address")
      `CHK(link_return_ea, mb ? sum : {32'h0000_0000, sum[31:0]}, "link address")
      `CHK(update_ea, sum, "update address")
      `CHK(wr_data, result_val, "write data")
    end
    msr_val = 64'h8000_0000_0000_0000;
    $display("test mode done");
  endtask : test_mode

  task automatic test_async();
    int n;
    @(posedge sys_clk);
    #1;
    u_fm.exc_wait = 2;
    u_fm.raise_event();
    u_fm.send(32'h6000_0000, 1'b1);
    `CHK(issue_valid, 1'b1, "word before event")
    `CHK(async_take, 1'b1, "event taken")
    `CHK(fetch_ready, 1'b0, "stall on event")
    wait_ready();
    u_fm.raise_event();
    u_fm.send(32'h0000_0000, 1'b1);
    `CHK(illegal_req, 1'b1, "trap wins")
    `CHK(async_take, 1'b0, "event waits")
    n = 0;
    while (async_req !== 1'b0 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    `CHK(async_req, 1'b0, "pending event taken")
    wait_ready();
    $display("test async done");
  endtask : test_async

  initial begin
    repeat (8) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    test_reset();
    test_classes();
    test_burst();
    test_mode();
    test_async();
    end_sim();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_sim();
  end
endmodule : instr_class_mode_decoder_tb_top
